/* design/tcv_core.sv */
// Purpose: 16-bit timer with one channel and byte-access coherency latches
// Assumes: cpu strobes and debug halt are on clk; capture and clock pins are async
// Notes:   read data appears the cycle after the read strobe
// Summary of operation
// - capture mode read of either value byte latches both until other byte read
// - capture mode ignores cpu writes to channel value bytes
// - compare/pwm value writes buffer, then move as one 16-bit value
// - clock source 00 moves buffered value as soon as second byte written
// - clock running, compare mode moves value on next counter step
// - clock running, pwm moves value on counter step modulo-1 to modulo
// - free-running counter pwm update occurs as counter leaves 0xfffe
// - any channel control write resets channel value byte latching
// - capture read latch cleared by control write between the two reads
// - control write cancels pending compare/pwm value, register unchanged
// - counter, modulo, channel value coherent in either byte order
// - debug halt counter reads return frozen live counter
// - debug halt timer control or counter write resets counter read latch
// - debug halt channel value reads return real register contents
// - debug halt channel control write resets channel read latch
// - debug halt timer control write resets modulo write latch
`timescale 1ns/1ps
`default_nettype none
module tcv_core (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire tcv_pkg::tcv_req_s req,
  input  wire logic            debug_halt,
  input  wire logic            capt_pin,
  input  wire logic            ext_clk_pin,
  output var  logic [7:0]      rd_data,
  output var  logic            chan_pin,
  output var  logic            chan_flag,
  output var  logic            ovf_flag
);
  import tcv_pkg::*;

  logic [7:0]          tsc_ff, csc_ff, rd_data_ff;
  logic [15:0]         cnt_ff, mod_ff, cv_ff, cnt_buf_ff, cv_rbuf_ff, cv_wbuf_ff;
  logic [7:0]          mod_buf_ff;
  logic                cnt_lat_ff, cnt_first_hi_ff, cv_lat_ff, cv_first_hi_ff;
  logic                mod_half_ff, mod_first_hi_ff, down_ff, out_ff;
  logic [TCV_PS_W-1:0] ps_ff;
  tcv_cvw_e            cvw_ff, nxt_cvw;
  logic [2:0]          sync_ff [TCV_SYNC_N];
  logic [TCV_SYNC_N-1:0] lvl_ff, prev_ff;

  // async pins: three flops, level accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < TCV_SYNC_N; gi++) begin : g_sync
      wire logic pin_in = (gi == 0) ? capt_pin : ext_clk_pin;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync_ff[gi] <= 3'h0;
          lvl_ff[gi]  <= 1'b0;
          prev_ff[gi] <= 1'b0;
        end else begin
          sync_ff[gi] <= {sync_ff[gi][1:0], pin_in};
          if (sync_ff[gi][1] == sync_ff[gi][2]) lvl_ff[gi] <= sync_ff[gi][2];
          prev_ff[gi] <= lvl_ff[gi];
        end
      end
    end
  endgenerate

  // decode
  wire logic [1:0] clock_source_select    = tsc_ff[TCV_TSC_CLOCK_SOURCE_SELECT_LSB +: 2];
  wire logic [2:0] ps      = tsc_ff[TCV_TSC_PS_LSB +: 3];
  wire logic       cpwm    = tsc_ff[TCV_TSC_CPWM];
  wire logic [1:0] ms      = csc_ff[TCV_CSC_MS_LSB +: 2];
  wire logic [1:0] els     = csc_ff[TCV_CSC_ELS_LSB +: 2];
  wire logic       m_capt  = !cpwm && (ms == TCV_MS_CAPT);
  wire logic       m_oc    = !cpwm && (ms == TCV_MS_OC);
  wire logic       m_pwm   = cpwm || ms[1];
  wire logic       clk_off = (clock_source_select == TCV_CLOCK_SOURCE_SELECT_OFF);
  wire logic       wr      = req.wr;
  wire logic       rd      = req.rd;
  wire logic       sel_hi  = !req.sel[0];
  wire logic       wr_tsc  = wr && (req.sel == TCV_SEL_TMR_SC);
  wire logic       wr_csc  = wr && (req.sel == TCV_SEL_CH_SC);
  wire logic       wr_cnt  = wr && (req.sel == TCV_SEL_CNT_HI || req.sel == TCV_SEL_CNT_LO);
  wire logic       wr_mod  = wr && (req.sel == TCV_SEL_MOD_HI || req.sel == TCV_SEL_MOD_LO);
  wire logic       wr_cv   = wr && (req.sel == TCV_SEL_CV_HI || req.sel == TCV_SEL_CV_LO);
  wire logic       rd_cnt  = rd && (req.sel == TCV_SEL_CNT_HI || req.sel == TCV_SEL_CNT_LO);
  wire logic       rd_cv   = rd && (req.sel == TCV_SEL_CV_HI || req.sel == TCV_SEL_CV_LO);

  // prescaler source: bus clock or synced external edge; 00 stops all
  wire logic       ext_rise = lvl_ff[1] && !prev_ff[1];
  wire logic       src_en   = !debug_halt && ((clock_source_select == TCV_CLOCK_SOURCE_SELECT_BUS) || (!clk_off && clock_source_select[1] && ext_rise));
  wire logic [TCV_PS_W-1:0] ps_mask = TCV_PS_W'((1 << ps) - 1);
  wire logic       tick     = src_en && ((ps_ff & ps_mask) == ps_mask);

  wire logic [15:0] top     = (mod_ff == TCV_MOD_RST) ? TCV_FREE_TOP : mod_ff;
  wire logic [15:0] top_m1  = (mod_ff == TCV_MOD_RST) ? TCV_FREE_UPD : mod_ff - 16'h0001;
  wire logic       at_pre   = !down_ff && (cnt_ff == top_m1);
  wire logic       pwm_evt  = tick && at_pre;
  wire logic       match    = tick && (cnt_ff == cv_ff);
  wire logic       capt_evt = m_capt && (lvl_ff[0] != prev_ff[0]) &&
                              ((els[0] && lvl_ff[0]) || (els[1] && !lvl_ff[0]));
  wire logic       cv_xfer  = (cvw_ff == TCV_CV_PEND) && !wr_csc &&
                              (clk_off || (m_oc && tick) || (m_pwm && pwm_evt));
  wire logic       wrap_up  = !cpwm && (cnt_ff == top);

  // channel value write buffer; a lone byte waits for its partner
  always_comb begin
    nxt_cvw = cvw_ff;
    if (wr_csc || m_capt) begin
      nxt_cvw = TCV_CV_IDLE;
    end else if (wr_cv) begin
      if ((sel_hi && cvw_ff == TCV_CV_HAVE_LO) || (!sel_hi && cvw_ff == TCV_CV_HAVE_HI)) begin
        nxt_cvw = TCV_CV_PEND;
      end else begin
        nxt_cvw = sel_hi ? TCV_CV_HAVE_HI : TCV_CV_HAVE_LO;
      end
    end else if (cv_xfer) begin
      nxt_cvw = TCV_CV_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cvw_ff     <= TCV_CV_IDLE;
      cv_wbuf_ff <= TCV_CV_RST;
    end else begin
      cvw_ff <= nxt_cvw;
      if (wr_cv && !m_capt && sel_hi) cv_wbuf_ff[15:8] <= req.data;
      if (wr_cv && !m_capt && !sel_hi) cv_wbuf_ff[7:0] <= req.data;
    end
  end

  // channel value register, capture and output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cv_ff     <= TCV_CV_RST;
      out_ff    <= 1'b0;
      chan_flag <= 1'b0;
    end else begin
      if (capt_evt) cv_ff <= cnt_ff;
      else if (cv_xfer) cv_ff <= cv_wbuf_ff;
      if (m_pwm) out_ff <= (cnt_ff < cv_ff);
      else if (m_oc && match) out_ff <= !out_ff;
      // set wins over the clear
      if (capt_evt || ((m_oc || m_pwm) && match)) chan_flag <= 1'b1;
      else if (wr_csc && !req.data[TCV_CSC_CHF]) chan_flag <= 1'b0;
    end
  end

  // channel value read latch, capture mode only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cv_lat_ff      <= 1'b0;
      cv_first_hi_ff <= 1'b0;
      cv_rbuf_ff     <= TCV_CV_RST;
    end else if (wr_csc) begin
      cv_lat_ff <= 1'b0;
    end else if (rd_cv && m_capt && !debug_halt) begin
      if (!cv_lat_ff) begin
        cv_lat_ff      <= 1'b1;
        cv_rbuf_ff     <= cv_ff;
        cv_first_hi_ff <= sel_hi;
      end else if (sel_hi != cv_first_hi_ff) begin
        cv_lat_ff <= 1'b0;
      end
    end
  end

  // counter, prescaler and overflow
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff   <= TCV_CNT_RST;
      ps_ff    <= '0;
      down_ff  <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      if (wr_cnt || wr_tsc) ps_ff <= '0;
      else if (src_en) ps_ff <= ps_ff + 1'b1;
      if (wr_cnt) begin
        cnt_ff  <= TCV_CNT_RST;
        down_ff <= 1'b0;
      end else if (tick) begin
        if (wrap_up) cnt_ff <= TCV_CNT_RST;
        else if (down_ff) cnt_ff <= cnt_ff - 16'h0001;
        else cnt_ff <= cnt_ff + 16'h0001;
        if (cpwm && !down_ff && cnt_ff == top_m1) down_ff <= 1'b1;
        if (cpwm && down_ff && cnt_ff == 16'h0001) down_ff <= 1'b0;
      end
      if (tick && (wrap_up || (cpwm && down_ff && cnt_ff == 16'h0001))) ovf_flag <= 1'b1;
      else if (wr_tsc && !req.data[TCV_TSC_TOF]) ovf_flag <= 1'b0;
    end
  end

  // counter read latch; frozen reads in debug bypass it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_lat_ff      <= 1'b0;
      cnt_first_hi_ff <= 1'b0;
      cnt_buf_ff      <= TCV_CNT_RST;
    end else if (wr_cnt || (debug_halt && wr_tsc)) begin
      cnt_lat_ff <= 1'b0;
    end else if (rd_cnt && !debug_halt) begin
      if (!cnt_lat_ff) begin
        cnt_lat_ff      <= 1'b1;
        cnt_buf_ff      <= cnt_ff;
        cnt_first_hi_ff <= sel_hi;
      end else if (sel_hi != cnt_first_hi_ff) begin
        cnt_lat_ff <= 1'b0;
      end
    end
  end

  // modulo write latch and control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mod_ff          <= TCV_MOD_RST;
      mod_buf_ff      <= 8'h00;
      mod_half_ff     <= 1'b0;
      mod_first_hi_ff <= 1'b0;
      tsc_ff          <= TCV_TSC_RST;
      csc_ff          <= TCV_CSC_RST;
    end else begin
      if (wr_tsc) tsc_ff <= req.data;
      if (wr_csc) csc_ff <= req.data;
      if (debug_halt && wr_tsc) begin
        mod_half_ff <= 1'b0;
      end else if (wr_mod) begin
        if (mod_half_ff && sel_hi != mod_first_hi_ff) begin
          mod_ff      <= sel_hi ? {req.data, mod_buf_ff} : {mod_buf_ff, req.data};
          mod_half_ff <= 1'b0;
        end else begin
          mod_buf_ff      <= req.data;
          mod_half_ff     <= 1'b1;
          mod_first_hi_ff <= sel_hi;
        end
      end
    end
  end

  // read mux; the latch only serves a read when not halted
  wire logic [15:0] cnt_view = (cnt_lat_ff && !debug_halt) ? cnt_buf_ff : cnt_ff;
  wire logic [15:0] cv_view  = (cv_lat_ff && !debug_halt) ? cv_rbuf_ff : cv_ff;
  logic [7:0] rd_mux;
  always_comb begin
    case (req.sel)
      TCV_SEL_CNT_HI: rd_mux = cnt_view[15:8];
      TCV_SEL_CNT_LO: rd_mux = cnt_view[7:0];
      TCV_SEL_MOD_HI: rd_mux = mod_ff[15:8];
      TCV_SEL_MOD_LO: rd_mux = mod_ff[7:0];
      TCV_SEL_CV_HI:  rd_mux = cv_view[15:8];
      TCV_SEL_CV_LO:  rd_mux = cv_view[7:0];
      TCV_SEL_CH_SC:  rd_mux = {chan_flag, csc_ff[6:0]};
      TCV_SEL_TMR_SC: rd_mux = {ovf_flag, tsc_ff[6:0]};
      default:        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rd_data_ff <= 8'h00;
    else if (rd) rd_data_ff <= rd_mux;
  end

  assign rd_data  = rd_data_ff;
  assign chan_pin = out_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_capt_no_write: assert property (
    m_capt && wr_cv |=> cvw_ff == TCV_CV_IDLE && $stable(cv_wbuf_ff))
    else $error("value write accepted in capture mode");
  chk_clkoff_commit: assert property (
    clk_off && !m_capt && cvw_ff == TCV_CV_PEND && !wr_csc
    |=> cv_ff == $past(cv_wbuf_ff) || $past(capt_evt))
    else $error("stopped clock did not commit value");
  chk_oc_wait_tick: assert property (
    m_oc && !clk_off && cvw_ff == TCV_CV_PEND && !tick && !wr_cv && !wr_csc
    |=> cvw_ff == TCV_CV_PEND)
    else $error("compare value moved without counter step");
  chk_pwm_no_early: assert property (
    m_pwm && !clk_off && cvw_ff == TCV_CV_PEND && !pwm_evt && !wr_cv && !wr_csc
    |=> $stable(cv_ff))
    else $error("pwm value moved off the period boundary");
  chk_free_upd: assert property (
    m_pwm && mod_ff == TCV_MOD_RST && cv_xfer && !clk_off |-> cnt_ff == TCV_FREE_UPD)
    else $error("free-running pwm update not at fffe");
  chk_csc_cancel: assert property (
    wr_csc && cvw_ff == TCV_CV_PEND && !capt_evt |=> cvw_ff == TCV_CV_IDLE && $stable(cv_ff))
    else $error("control write did not cancel pending value");
  chk_csc_rd_clr: assert property (wr_csc |=> !cv_lat_ff)
    else $error("channel read latch survived control write");
  chk_cnt_frozen: assert property (
    debug_halt && rd && req.sel == TCV_SEL_CNT_LO |=> rd_data == $past(cnt_ff[7:0]))
    else $error("halted counter read not live");
  chk_cv_real: assert property (
    debug_halt && rd && req.sel == TCV_SEL_CV_HI |=> rd_data == $past(cv_ff[15:8]))
    else $error("halted value read came from buffer");
  chk_halt_cnt_clr: assert property (debug_halt && wr_tsc |=> !cnt_lat_ff)
    else $error("counter latch survived halted control write");
  chk_halt_mod_clr: assert property (debug_halt && wr_tsc |=> !mod_half_ff)
    else $error("modulo latch survived halted control write");
  chk_single_byte: assert property (
    (cvw_ff == TCV_CV_HAVE_HI || cvw_ff == TCV_CV_HAVE_LO) && !wr_cv
    |=> $stable(cv_ff) || $past(capt_evt))
    else $error("lone value byte moved");
  // the latched pair must survive anything but the partner read or a control write
  chk_capt_hold: assert property (
    cv_lat_ff && !wr_csc && !(rd_cv && m_capt && !debug_halt && sel_hi != cv_first_hi_ff)
    |=> cv_lat_ff && $stable(cv_rbuf_ff))
    else $error("capture latch hold broken");

  cov_pwm_xfer:  cover property (m_pwm && !clk_off && cv_xfer);
  cov_oc_xfer:   cover property (m_oc && !clk_off && cv_xfer);
  cov_cancel:    cover property (cvw_ff == TCV_CV_PEND && wr_csc);
  cov_capt_read: cover property (cv_lat_ff && capt_evt);
endmodule : tcv_core
`default_nettype wire

/* design/tcv_pkg.sv */
// Purpose: shared types and constants for the timer channel value coherency block
// Assumes: byte-wide cpu access, one channel, 10 MHz bus clock
// Notes:   field positions refer to the status and control bytes
package tcv_pkg;

  // cpu byte select
  typedef enum logic [2:0] {
    TCV_SEL_CNT_HI  = 3'b000,
    TCV_SEL_CNT_LO  = 3'b001,
    TCV_SEL_MOD_HI  = 3'b010,
    TCV_SEL_MOD_LO  = 3'b011,
    TCV_SEL_CV_HI   = 3'b100,
    TCV_SEL_CV_LO   = 3'b101,
    TCV_SEL_CH_SC   = 3'b110,
    TCV_SEL_TMR_SC  = 3'b111
  } tcv_sel_e;

  // one cpu access, valid for one cycle
  typedef struct packed {
    logic       rd;
    logic       wr;
    tcv_sel_e   sel;
    logic [7:0] data;
  } tcv_req_s;

  // channel value write buffer state
  typedef enum logic [1:0] {
    TCV_CV_IDLE    = 2'b00,
    TCV_CV_HAVE_HI = 2'b01,
    TCV_CV_HAVE_LO = 2'b10,
    TCV_CV_PEND    = 2'b11
  } tcv_cvw_e;

  // timer_status_control fields
  localparam int TCV_TSC_TOF      = 7;
  localparam int TCV_TSC_CPWM     = 5;
  localparam int TCV_TSC_CLOCK_SOURCE_SELECT_LSB = 3;
  localparam int TCV_TSC_PS_LSB   = 0;
  // chan_status_control fields
  localparam int TCV_CSC_CHF      = 7;
  localparam int TCV_CSC_MS_LSB   = 4;
  localparam int TCV_CSC_ELS_LSB  = 2;

  localparam logic [1:0]  TCV_CLOCK_SOURCE_SELECT_OFF  = 2'h0;
  localparam logic [1:0]  TCV_CLOCK_SOURCE_SELECT_BUS  = 2'h1;
  localparam logic [1:0]  TCV_MS_CAPT   = 2'h0;
  localparam logic [1:0]  TCV_MS_OC     = 2'h1;
  localparam logic [15:0] TCV_FREE_TOP  = 16'hffff;
  localparam logic [15:0] TCV_FREE_UPD  = 16'hfffe;
  localparam logic [15:0] TCV_CNT_RST   = 16'h0000;
  localparam logic [15:0] TCV_MOD_RST   = 16'h0000;
  localparam logic [15:0] TCV_CV_RST    = 16'h0000;
  localparam logic [7:0]  TCV_TSC_RST   = 8'h00;
  localparam logic [7:0]  TCV_CSC_RST   = 8'h00;
  localparam int          TCV_PS_W      = 7;
  localparam int          TCV_SYNC_N    = 2;

endpackage : tcv_pkg

/* testbench/tcv_cpu_model.sv */
// Purpose: cpu bus model, one byte access per call
// Assumes: a strobe is taken at the next rising edge
// Notes:   idle data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module tcv_cpu_model (
  input  wire logic              clk,
  input  wire logic [7:0]        rd_data,
  output var  tcv_pkg::tcv_req_s req
);
  import tcv_pkg::*;
  initial begin
    req = '{1'b0, 1'b0, TCV_SEL_CNT_HI, 8'h00};
  end
  // one idle edge between accesses, so no strobe is set twice in one step
  task automatic acc(input logic r, input tcv_sel_e s, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    req = '{r, ~r, s, d};
    @(posedge clk);
    #1;
    q = rd_data;
    req = '{1'b0, 1'b0, s, ~d};
  endtask : acc
  // a byte pair always goes out whole, in the order asked for
  task automatic pair(input logic r, input tcv_sel_e hi, input logic lo1,
                      input logic [15:0] w, output logic [15:0] v);
    tcv_sel_e lo;
    lo = tcv_sel_e'(hi + 3'h1);
    if (lo1) begin
      acc(r, lo, w[7:0], v[7:0]);
    end
    acc(r, hi, w[15:8], v[15:8]);
    if (!lo1) begin
      acc(r, lo, w[7:0], v[7:0]);
    end
  endtask : pair
endmodule : tcv_cpu_model
`default_nettype wire

/* testbench/tcv_core_tb_top.sv */
// Purpose: self-checking bench for the channel value coherency timer
// Assumes: external clock pin unused, held low
// Notes:   the free-running pwm case waits one full counter lap
`timescale 1ns/1ps
`default_nettype none
module tcv_core_tb_top;
  import tcv_pkg::*;
  logic        clk;
  logic        resetn;
  logic        debug_halt;
  logic        capt_pin;
  logic        ext_clk_pin;
  tcv_req_s    req;
  logic [7:0]  rd_data;
  logic [2:0]  outs;
  logic [7:0]  q;
  logic [15:0] lfsr_q;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] f;
  logic [15:0] exp_cv;
  int          miscompares;
  int          n_compared;

  tcv_core dut (.clk(clk), .resetn(resetn), .req(req), .debug_halt(debug_halt),
    .capt_pin(capt_pin), .ext_clk_pin(ext_clk_pin), .rd_data(rd_data),
    .chan_pin(outs[2]), .chan_flag(outs[1]), .ovf_flag(outs[0]));
  tcv_cpu_model cpu (.clk(clk), .rd_data(rd_data), .req(req));

  always #50 clk = ~clk;

  task automatic check(input logic [15:0] got, input logic [15:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // xor with an odd value, so a missed transfer can never look right
  function automatic logic [15:0] fresh(input logic [15:0] old);
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return old ^ (lfsr_q | 16'h0001);
  endfunction : fresh
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input tcv_sel_e s, input logic [7:0] d);
    cpu.acc(1'b0, s, d, q);
  endtask : wr
  task automatic rd(input tcv_sel_e s);
    cpu.acc(1'b1, s, 8'h00, q);
  endtask : rd
  task automatic r16(input tcv_sel_e s, input logic lo1);
    cpu.pair(1'b1, s, lo1, 16'h0000, b);
  endtask : r16
  task automatic chk_cv(input logic lo1);
    r16(TCV_SEL_CV_HI, lo1);
    check(b, exp_cv);
  endtask : chk_cv
  task automatic halt_cv();
    debug_halt = 1'b1;
    r16(TCV_SEL_CV_HI, 1'b0);
    debug_halt = 1'b0;
  endtask : halt_cv
  task automatic capture();
    capt_pin = 1'b1;
    cyc(12);
    capt_pin = 1'b0;
    cyc(30);
  endtask : capture

  initial begin
    #(100 * 90000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    debug_halt = 1'b0;
    capt_pin = 1'b0;
    ext_clk_pin = 1'b0;
    lfsr_q = 16'h0063;
    miscompares = 0;
    n_compared = 0;
    exp_cv = TCV_CV_RST;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    check({13'h0, outs}, 16'h0000);
    cpu.pair(1'b0, TCV_SEL_CV_HI, 1'b0, fresh(exp_cv), b);
    chk_cv(1'b0);
    wr(TCV_SEL_CH_SC, 8'h04);
    wr(TCV_SEL_TMR_SC, 8'h08);
    cyc(9 + int'(lfsr_q[3:0]));
    capture();
    halt_cv();
    a = b;
    rd(TCV_SEL_CV_HI);
    check({8'h00, q}, {8'h00, a[15:8]});
    capture();
    halt_cv();
    check({15'h0, b == a}, 16'h0000);
    rd(TCV_SEL_CV_LO);
    check({8'h00, q}, {8'h00, a[7:0]});
    f = b;
    r16(TCV_SEL_CV_HI, 1'b1);
    check(b, f);
    rd(TCV_SEL_CV_HI);
    wr(TCV_SEL_CH_SC, 8'h04);
    capture();
    halt_cv();
    exp_cv = b;
    rd(TCV_SEL_CV_LO);
    check({8'h00, q}, {8'h00, exp_cv[7:0]});
    rd(TCV_SEL_CV_HI);
    // counter snapshot, then a wait long enough for the high byte to move, then a halt
    rd(TCV_SEL_CNT_HI);
    a = {q, 8'h00};
    cyc(300);
    debug_halt = 1'b1;
    r16(TCV_SEL_CNT_HI, 1'b1);
    f = b;
    rd(TCV_SEL_CNT_LO);
    check({8'h00, q}, {8'h00, f[7:0]});
    check({15'h0, (f[15:8] - a[15:8]) inside {8'h01, 8'h02}}, 16'h0001);
    wr(TCV_SEL_TMR_SC, 8'h08);
    debug_halt = 1'b0;
    r16(TCV_SEL_CNT_HI, 1'b1);
    check({15'h0, (b - f) < 16'h0010}, 16'h0001);
    wr(TCV_SEL_TMR_SC, 8'h00);
    wr(TCV_SEL_CH_SC, 8'h10);
    a = fresh(exp_cv);
    wr(TCV_SEL_CV_LO, a[7:0]);
    chk_cv(1'b0);
    wr(TCV_SEL_CV_HI, a[15:8]);
    exp_cv = a;
    chk_cv(1'b1);
    wr(TCV_SEL_TMR_SC, 8'h0f);
    wr(TCV_SEL_CNT_LO, 8'h00);
    cpu.pair(1'b0, TCV_SEL_CV_HI, 1'b0, fresh(exp_cv), b);
    chk_cv(1'b0);
    wr(TCV_SEL_CH_SC, 8'h10);
    cyc(300);
    chk_cv(1'b0);
    wr(TCV_SEL_CNT_LO, 8'h00);
    a = fresh(exp_cv);
    cpu.pair(1'b0, TCV_SEL_CV_HI, 1'b1, a, b);
    cyc(140);
    exp_cv = a;
    chk_cv(1'b0);
    wr(TCV_SEL_TMR_SC, 8'h00);
    cpu.pair(1'b0, TCV_SEL_MOD_HI, 1'b1, 16'h0040, b);
    debug_halt = 1'b1;
    wr(TCV_SEL_MOD_LO, 8'h80);
    wr(TCV_SEL_TMR_SC, 8'h00);
    wr(TCV_SEL_MOD_HI, 8'h00);
    debug_halt = 1'b0;
    r16(TCV_SEL_MOD_HI, 1'b0);
    check(b, 16'h0040);
    wr(TCV_SEL_MOD_LO, 8'h40);
    wr(TCV_SEL_CH_SC, 8'h20);
    wr(TCV_SEL_TMR_SC, 8'h08);
    wr(TCV_SEL_CNT_LO, 8'h00);
    a = fresh(exp_cv);
    cpu.pair(1'b0, TCV_SEL_CV_HI, 1'b0, a, b);
    cyc(40);
    chk_cv(1'b0);
    cyc(40);
    exp_cv = a;
    chk_cv(1'b1);
    cpu.pair(1'b0, TCV_SEL_MOD_HI, 1'b0, 16'h0000, b);
    wr(TCV_SEL_CNT_LO, 8'h00);
    a = fresh(exp_cv);
    cpu.pair(1'b0, TCV_SEL_CV_HI, 1'b1, a, b);
    cyc(65400);
    chk_cv(1'b0);
    cyc(200);
    exp_cv = a;
    chk_cv(1'b0);
    tally_and_finish();
  end
endmodule : tcv_core_tb_top
`default_nettype wire
